// ---- tcsp_pkg.sv ----
// constants, types and helpers for the three-wire configuration serial port
// assumes a host that meets serial setup/hold around the rising serial clock edge
package tcsp_pkg;

	localparam int INSTR_BITS = 16;
	localparam int ADDR_BITS = 13;
	localparam int BYTE_BITS = 8;

	// instruction word layout, first received bit is bit 15 msb first, bit 0 lsb first
	localparam int INSTR_RNW_POS = 15;
	localparam int INSTR_LEN_HI = 14;
	localparam int INSTR_LEN_LO = 13;
	localparam int INSTR_ADDR_HI = 12;

	// length field encodings
	localparam logic [1:0] LEN_ONE = 2'h0;
	localparam logic [1:0] LEN_TWO = 2'h1;
	localparam logic [1:0] LEN_THREE = 2'h2;
	localparam logic [1:0] LEN_STREAM = 2'h3;

	// locally held registers
	localparam logic [12:0] ADDR_PORT_CONFIG = 13'h0000;
	localparam logic [12:0] ADDR_INDEX_2 = 13'h0004;
	localparam logic [12:0] ADDR_INDEX_1 = 13'h0005;
	localparam logic [12:0] ADDR_UPDATE = 13'h00FF;
	localparam logic [7:0] PORT_CONFIG_RST = 8'h18;
	localparam logic [7:0] INDEX_2_RST = 8'h0F;
	localparam logic [7:0] INDEX_1_RST = 8'h0F;
	localparam int BIT_LSB_HI = 6;
	localparam int BIT_LSB_LO = 1;
	localparam int BIT_XFER = 0;

	typedef enum logic [1:0] {
		PH_INSTR = 2'b00,
		PH_DATA = 2'b01
	} tcsp_phase_e;

	typedef struct packed {
		logic [12:0] addr;
		logic [7:0] data;
	} tcsp_wr_s;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < BYTE_BITS; i++) begin
			r[i] = v[BYTE_BITS-1-i];
		end
		return r;
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < INSTR_BITS; i++) begin
			r[i] = v[INSTR_BITS-1-i];
		end
		return r;
	endfunction

	// position within a byte of the k-th bit on the wire
	function automatic logic [2:0] bit_idx(input logic [2:0] k, input logic lsb);
		return lsb ? k : 3'h7 - k;
	endfunction

endpackage

// ---- tcsp_port.sv ----
// device end of the three-wire configuration serial port
// assumes serial clock, select and data meet setup/hold to the serial clock;
// the register bank answers RD_DATA combinationally from RD_ADDR
//
// Summary of operation
// RULE1 - select falling then clock rising starts a new instruction frame; a gap on a byte boundary of a 1-3 byte frame keeps position instead
// RULE2 - frame is a 16-bit instruction, then data bytes counted by the length bits
// RULE3 - length 11 streams bytes until select returns high
// RULE4 - one to three byte frames keep position across select high between bytes
// RULE5 - select high inside a partial byte resets the frame, new instruction awaited
// RULE6 - clock and data are acted on only while select is low
// RULE7 - select tied low gives two-wire mode, framing kept from power-up sync
// RULE8 - two-wire streaming is entered and never left
// RULE9 - host should use one to three byte frames in two-wire mode
// RULE10 - instruction selects write or readback of the addressed registers
// RULE11 - readback turns the data line to output after the instruction
// RULE12 - clock and select are inputs; data line drives only during readback
// RULE13 - most significant bit first after power-up; config selects lsb first
// RULE14 - serial state comes out of power-up ready for an instruction
// RULE15 - bit order lives in mirrored bits 6 and 1 of port config
// RULE16 - incoming bits are sampled on the rising serial clock edge
// RULE17 - channel index writes are held until the transfer bit is set
// RULE18 - length 00 one byte, 01 two, 10 three, 11 streaming
// RULE19 - instruction: read flag, two length bits, 13-bit address; address steps per byte
`timescale 1ns/1ps
module tcsp_port (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic SCLK,
	input wire logic SELECT_LOW_N,
	input wire logic SDIO_I,
	output logic SDIO_O,
	output logic SDIO_OE,
	output logic [12:0] RD_ADDR,
	input wire logic [7:0] RD_DATA,
	output logic WR_STRB,
	output tcsp_pkg::tcsp_wr_s WR_WORD,
	output logic [7:0] CHAN_INDEX_2,
	output logic [7:0] CHAN_INDEX_1,
	output logic STREAMING,
	output logic LSB_FIRST
);

	typedef struct packed {
		logic [15:0] shift;
		logic [3:0] bit_cnt;
		tcsp_pkg::tcsp_phase_e phase;
		logic rnw;
		logic [1:0] len;
		logic [12:0] addr;
		logic [1:0] bytes_left;
		logic stream;
		logic lsb_first;
		logic [7:0] idx2_hold;
		logic [7:0] idx1_hold;
		logic wr_tgl;
		tcsp_pkg::tcsp_wr_s wr;
		logic xfer_tgl;
	} tcsp_link_s;

	typedef struct packed {
		logic oe;
		logic sdo;
		logic [7:0] data;
	} tcsp_tx_s;

	typedef struct packed {
		logic link_rst;
		logic pw_s1;
		logic pw_s2;
		logic armed;
		logic wr_s1;
		logic wr_s2;
		logic wr_s3;
		logic xf_s1;
		logic xf_s2;
		logic xf_s3;
		logic st_s1;
		logic st_s2;
		logic lo_s1;
		logic lo_s2;
		logic wr_strb;
		tcsp_pkg::tcsp_wr_s wr;
		logic [7:0] idx2;
		logic [7:0] idx1;
		logic streaming;
		logic lsb_first;
	} tcsp_sys_s;

	tcsp_link_s lk_q, lk_d;
	tcsp_tx_s tx_q, tx_d;
	tcsp_sys_s sy_q, sy_d;
	logic pwr_q;
	logic gap_q;
	logic restart;
	logic [15:0] word;
	logic [7:0] rxb;
	logic [7:0] rd;
	logic mid_byte;

	// power-up marker: set by system reset, cleared by the first serial edge
	always_ff @(posedge SCLK or posedge sy_q.link_rst) begin
		if (sy_q.link_rst) begin
			pwr_q <= 1'b1;
		end else begin
			pwr_q <= 1'b0;
		end
	end

	// select-high marker: set while select is high, cleared at a selected edge
	always_ff @(posedge SCLK or posedge SELECT_LOW_N) begin
		if (SELECT_LOW_N) begin
			gap_q <= 1'b1;
		end else begin
			gap_q <= 1'b0;
		end
	end

	assign mid_byte = (lk_q.bit_cnt[2:0] != 3'h0);

	// link receive engine, rising serial clock
	always_comb begin
		lk_d = lk_q;
		restart = 1'b0;
		word = '0;
		rxb = '0;
		if (pwr_q) begin
			lk_d = '0; // [RULE14]
			lk_d.lsb_first = 1'b0; // [RULE13]
			lk_d.idx2_hold = tcsp_pkg::INDEX_2_RST;
			lk_d.idx1_hold = tcsp_pkg::INDEX_1_RST;
		end
		if (!SELECT_LOW_N) begin // [RULE6]
			// a select-high gap inside a byte or a stream starts over [RULE5] [RULE3]
			restart = pwr_q | (gap_q & (mid_byte | lk_q.stream)); // [RULE1] [RULE4]
			if (restart) begin
				lk_d.phase = tcsp_pkg::PH_INSTR;
				lk_d.bit_cnt = 4'h0;
				lk_d.stream = 1'b0;
			end
			lk_d.shift = {lk_d.shift[14:0], SDIO_I}; // [RULE16]
			case (lk_d.phase)
				tcsp_pkg::PH_INSTR: begin
					if (lk_d.bit_cnt == 4'hF) begin // [RULE2]
						word = lk_d.lsb_first ? tcsp_pkg::rev16(lk_d.shift) : lk_d.shift;
						lk_d.rnw = word[tcsp_pkg::INSTR_RNW_POS]; // [RULE10] [RULE19]
						lk_d.len = word[tcsp_pkg::INSTR_LEN_HI:tcsp_pkg::INSTR_LEN_LO];
						lk_d.addr = word[tcsp_pkg::INSTR_ADDR_HI:0];
						lk_d.bytes_left = lk_d.len; // [RULE18]
						lk_d.stream = (lk_d.len == tcsp_pkg::LEN_STREAM); // [RULE3] [RULE8]
						lk_d.phase = tcsp_pkg::PH_DATA;
						lk_d.bit_cnt = 4'h0;
					end else begin
						lk_d.bit_cnt = lk_d.bit_cnt + 4'h1;
					end
				end
				tcsp_pkg::PH_DATA: begin
					if (lk_d.bit_cnt == 4'h7) begin
						rxb = lk_d.lsb_first ? tcsp_pkg::rev8(lk_d.shift[7:0]) : lk_d.shift[7:0];
						if (!lk_d.rnw) begin // [RULE10]
							lk_d.wr.addr = lk_d.addr;
							lk_d.wr.data = rxb;
							lk_d.wr_tgl = ~lk_d.wr_tgl;
							case (lk_d.addr)
								tcsp_pkg::ADDR_PORT_CONFIG: begin
									lk_d.lsb_first = rxb[tcsp_pkg::BIT_LSB_HI] | rxb[tcsp_pkg::BIT_LSB_LO]; // [RULE15]
								end
								tcsp_pkg::ADDR_INDEX_2: begin
									lk_d.idx2_hold = rxb; // [RULE17]
								end
								tcsp_pkg::ADDR_INDEX_1: begin
									lk_d.idx1_hold = rxb; // [RULE17]
								end
								tcsp_pkg::ADDR_UPDATE: begin
									if (rxb[tcsp_pkg::BIT_XFER]) begin
										lk_d.xfer_tgl = ~lk_d.xfer_tgl; // [RULE17]
									end
								end
								default: begin
									lk_d.xfer_tgl = lk_d.xfer_tgl;
								end
							endcase
						end
						// address steps down msb first, up lsb first [RULE19]
						lk_d.addr = lk_d.lsb_first ? lk_d.addr + 13'h0001 : lk_d.addr - 13'h0001;
						if (!lk_d.stream) begin
							if (lk_d.bytes_left == 2'h0) begin
								lk_d.phase = tcsp_pkg::PH_INSTR; // [RULE7]
							end else begin
								lk_d.bytes_left = lk_d.bytes_left - 2'h1;
							end
						end
						lk_d.bit_cnt = 4'h0;
					end else begin
						lk_d.bit_cnt = lk_d.bit_cnt + 4'h1;
					end
				end
				default: begin
					lk_d.phase = tcsp_pkg::PH_INSTR;
					lk_d.bit_cnt = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge SCLK) begin
		lk_q <= lk_d;
	end

	// readback source: local registers, else the outside register bank
	always_comb begin
		rd = RD_DATA;
		case (lk_q.addr)
			tcsp_pkg::ADDR_PORT_CONFIG: begin
				rd = tcsp_pkg::PORT_CONFIG_RST;
				rd[tcsp_pkg::BIT_LSB_HI] = lk_q.lsb_first;
				rd[tcsp_pkg::BIT_LSB_LO] = lk_q.lsb_first;
			end
			tcsp_pkg::ADDR_INDEX_2: begin
				rd = lk_q.idx2_hold;
			end
			tcsp_pkg::ADDR_INDEX_1: begin
				rd = lk_q.idx1_hold;
			end
			tcsp_pkg::ADDR_UPDATE: begin
				rd = 8'h00;
			end
			default: begin
				rd = RD_DATA;
			end
		endcase
	end

	// readback driver, falling serial clock
	always_comb begin
		tx_d = tx_q;
		if (pwr_q) begin
			tx_d = '0;
		end else if (lk_q.phase == tcsp_pkg::PH_DATA && lk_q.rnw) begin
			tx_d.oe = 1'b1; // [RULE11]
			if (lk_q.bit_cnt[2:0] == 3'h0) begin
				tx_d.data = rd;
				tx_d.sdo = rd[tcsp_pkg::bit_idx(3'h0, lk_q.lsb_first)]; // [RULE13]
			end else begin
				tx_d.sdo = tx_q.data[tcsp_pkg::bit_idx(lk_q.bit_cnt[2:0], lk_q.lsb_first)];
			end
		end else begin
			tx_d.oe = 1'b0;
		end
	end

	always_ff @(negedge SCLK) begin
		tx_q <= tx_d;
	end

	// drive only in readback, never while deselected or after an aborting gap
	assign SDIO_OE = tx_q.oe & ~SELECT_LOW_N & ~pwr_q & ~(gap_q & (lk_q.stream | mid_byte)); // [RULE12]
	assign SDIO_O = tx_q.sdo;
	assign RD_ADDR = lk_q.addr;

	// system side: crossings of write events, transfer events and status
	always_comb begin
		sy_d = sy_q;
		sy_d.link_rst = SRST;
		sy_d.pw_s1 = pwr_q;
		sy_d.pw_s2 = sy_q.pw_s1;
		sy_d.armed = ~sy_q.pw_s2 & ~SRST;
		sy_d.wr_s1 = lk_q.wr_tgl;
		sy_d.wr_s2 = sy_q.wr_s1;
		sy_d.wr_s3 = sy_q.wr_s2;
		sy_d.xf_s1 = lk_q.xfer_tgl;
		sy_d.xf_s2 = sy_q.xf_s1;
		sy_d.xf_s3 = sy_q.xf_s2;
		sy_d.st_s1 = lk_q.stream;
		sy_d.st_s2 = sy_q.st_s1;
		sy_d.lo_s1 = lk_q.lsb_first;
		sy_d.lo_s2 = sy_q.lo_s1;
		sy_d.wr_strb = (sy_q.wr_s2 ^ sy_q.wr_s3) & sy_q.armed; // [RULE10]
		if ((sy_q.wr_s2 ^ sy_q.wr_s3) & sy_q.armed) begin
			sy_d.wr = lk_q.wr;
		end
		if ((sy_q.xf_s2 ^ sy_q.xf_s3) & sy_q.armed) begin
			sy_d.idx2 = lk_q.idx2_hold; // [RULE17]
			sy_d.idx1 = lk_q.idx1_hold;
		end
		sy_d.streaming = sy_q.st_s2 & sy_q.armed;
		sy_d.lsb_first = sy_q.lo_s2 & sy_q.armed;
		if (SRST) begin
			sy_d.armed = 1'b0;
			sy_d.wr_strb = 1'b0;
			sy_d.wr = '0;
			sy_d.idx2 = tcsp_pkg::INDEX_2_RST;
			sy_d.idx1 = tcsp_pkg::INDEX_1_RST;
			sy_d.streaming = 1'b0;
			sy_d.lsb_first = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		sy_q <= sy_d;
	end

	assign WR_STRB = sy_q.wr_strb;
	assign WR_WORD = sy_q.wr;
	assign CHAN_INDEX_2 = sy_q.idx2;
	assign CHAN_INDEX_1 = sy_q.idx1;
	assign STREAMING = sy_q.streaming;
	assign LSB_FIRST = sy_q.lsb_first;

	// checks
	AST_FRAME_START: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE1]
		(gap_q && !SELECT_LOW_N && lk_q.stream) |=>
			(lk_q.phase == tcsp_pkg::PH_INSTR && lk_q.bit_cnt == 4'h1))
		else $error("frame start did not restart instruction");

	AST_INSTR_DONE: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE2]
		(!SELECT_LOW_N && !gap_q && lk_q.phase == tcsp_pkg::PH_INSTR && lk_q.bit_cnt == 4'hF) |=>
			(lk_q.phase == tcsp_pkg::PH_DATA && lk_q.bit_cnt == 4'h0))
		else $error("instruction did not end after sixteen bits");

	AST_STREAM_HOLD: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE3]
		(!SELECT_LOW_N && !gap_q && lk_q.stream && lk_q.bit_cnt == 4'h7) |=>
			(lk_q.phase == tcsp_pkg::PH_DATA && lk_q.stream))
		else $error("streaming frame ended without select high");

	AST_STALL_KEEP: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE4]
		(gap_q && !SELECT_LOW_N && !lk_q.stream && lk_q.phase == tcsp_pkg::PH_DATA
			&& lk_q.bit_cnt == 4'h0) |=>
			(lk_q.phase == tcsp_pkg::PH_DATA && lk_q.bit_cnt == 4'h1))
		else $error("stall between bytes lost frame position");

	AST_ABORT: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE5]
		(gap_q && !SELECT_LOW_N && lk_q.bit_cnt[2:0] != 3'h0) |=>
			(lk_q.phase == tcsp_pkg::PH_INSTR && lk_q.bit_cnt == 4'h1))
		else $error("partial byte gap did not reset the frame");

	AST_IGNORE: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE6]
		(SELECT_LOW_N && !pwr_q) |=> (lk_q == $past(lk_q)))
		else $error("state changed while deselected");

	AST_DRIVE_DIR: assert property (@(posedge SCLK) disable iff (pwr_q) // [RULE12]
		SDIO_OE |-> (lk_q.rnw && lk_q.phase == tcsp_pkg::PH_DATA && !SELECT_LOW_N))
		else $error("data line driven outside readback");

	AST_MSB_AFTER_PWR: assert property (@(posedge SCLK) // [RULE13]
		pwr_q |=> !lk_q.lsb_first)
		else $error("bit order not msb first after power-up");

	AST_XFER_LOAD: assert property (@(posedge SYS_CLK) disable iff (SRST) // [RULE17]
		((sy_q.xf_s2 ^ sy_q.xf_s3) && sy_q.armed) |=> (CHAN_INDEX_2 == $past(lk_q.idx2_hold)))
		else $error("index not loaded by transfer");

	AST_WR_PULSE: assert property (@(posedge SYS_CLK) disable iff (SRST) // [RULE10]
		WR_STRB |=> !WR_STRB ##1 !WR_STRB)
		else $error("write strobe longer than one cycle");

endmodule // tcsp_port

// ---- tcsp_host.sv ----
// host model for the serial port: makes clock, select and data line
// assumes the bench resolves the shared data line with a pull-down
`timescale 1ns/1ps
module tcsp_host (
	output logic SCLK,
	output logic SELECT_LOW_N,
	output logic SDIO_H,
	output logic SDIO_H_OE,
	input wire logic SDIO_W
);
	initial begin
		SCLK = 1'h0;
		SELECT_LOW_N = 1'h1;
		SDIO_H = 1'h0;
		SDIO_H_OE = 1'h0;
	end
	// select moves only while the clock is low, clear of rising edges
	task automatic sel(input logic v);
		#20 SELECT_LOW_N = v;
		#20;
	endtask
	// n low bits of v, highest first; clock runs only here
	task automatic shift(input logic [15:0] v, input int n, input logic rd,
		output logic [15:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--) begin
			SDIO_H_OE = !rd;
			SDIO_H = v[i];
			#15 SCLK = 1'h1;
			r[i] = SDIO_W;
			#15 SCLK = 1'h0;
		end
		SDIO_H_OE = 1'h0;
	endtask
endmodule // tcsp_host

// ---- tcsp_port_bench.sv ----
// self-checking bench for the serial port: random frames and corner cases
// assumes tcsp_pkg, tcsp_port and tcsp_host are compiled first
`timescale 1ns/1ps
module tcsp_port_bench;
	logic sys_clk, srst, sclk, sel_n, h_d, h_oe, d_o, d_oe, sdio_w, wr_strb;
	logic streaming, lsb_first, lsb;
	logic [12:0] rd_addr;
	logic [7:0] rd_data, idx2, idx1, rd_key;
	logic [31:0] seed;
	tcsp_pkg::tcsp_wr_s wr_word;
	tcsp_pkg::tcsp_wr_s eq[$], wq[$];
	int n_mismatch, total_checks;

	function automatic logic [7:0] rdv(input logic [12:0] a);
		return a[7:0] ^ rd_key;
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	assign sdio_w = d_oe ? d_o : (h_oe ? h_d : 1'h0);
	assign rd_data = rdv(rd_addr);

	tcsp_port tcsp_port_i (.SYS_CLK(sys_clk), .SRST(srst), .SCLK(sclk),
		.SELECT_LOW_N(sel_n), .SDIO_I(sdio_w), .SDIO_O(d_o), .SDIO_OE(d_oe),
		.RD_ADDR(rd_addr), .RD_DATA(rd_data), .WR_STRB(wr_strb), .WR_WORD(wr_word),
		.CHAN_INDEX_2(idx2), .CHAN_INDEX_1(idx1), .STREAMING(streaming),
		.LSB_FIRST(lsb_first));
	tcsp_host tcsp_host_i (.SCLK(sclk), .SELECT_LOW_N(sel_n), .SDIO_H(h_d),
		.SDIO_H_OE(h_oe), .SDIO_W(sdio_w));

	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (wr_strb === 1'h1) wq.push_back(wr_word);

	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_w(input tcsp_pkg::tcsp_wr_s got, input tcsp_pkg::tcsp_wr_s exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t write got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic drain();
		tcsp_pkg::tcsp_wr_s g;
		repeat (12) @(posedge sys_clk);
		chk_b(8'(wq.size()), 8'(eq.size()));
		while (eq.size() > 0) begin
			g = (wq.size() > 0) ? wq.pop_front() : '0;
			chk_w(g, eq.pop_front());
		end
		wq.delete();
		chk_b({7'h0, d_oe}, 8'h0);
	endtask
	// select high with clocks that must be ignored
	task automatic gap();
		logic [15:0] r;
		tcsp_host_i.sel(1'h1);
		tcsp_host_i.shift(16'h0005, 3, 1'h0, r);
		tcsp_host_i.sel(1'h0);
	endtask
	task automatic frame(input logic rnw, input logic [1:0] len, input logic [12:0] a,
		input int n, input logic [31:0] d, input logic stall, input logic keep);
		logic [15:0] w, r;
		logic [7:0] b, bw, g;
		w = {rnw, len, a};
		r = {<<{w}};
		if (lsb) w = r;
		tcsp_host_i.sel(1'h0);
		if (stall) begin
			tcsp_host_i.shift({8'h0, w[15:8]}, 8, 1'h0, r);
			gap();
			tcsp_host_i.shift({8'h0, w[7:0]}, 8, 1'h0, r);
		end else tcsp_host_i.shift(w, 16, 1'h0, r);
		for (int i = 0; i < n; i++) begin
			b = d[31-8*i -: 8];
			bw = {<<{b}};
			if (!lsb) bw = b;
			tcsp_host_i.shift({8'h0, bw}, 8, rnw, r);
			g = {<<{r[7:0]}};
			if (!lsb) g = r[7:0];
			if (rnw) chk_b(g, b);
			else eq.push_back({lsb ? a + 13'(i) : a - 13'(i), b});
			if (len == 2'h3 && i == 1) chk_b({7'h0, streaming}, 8'h1);
			if (stall && i < n - 1) gap();
		end
		if (!keep) tcsp_host_i.sel(1'h1);
	endtask

	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end

	initial begin
		logic [12:0] a;
		logic [31:0] d;
		logic [15:0] r;
		n_mismatch = 0;
		total_checks = 0;
		seed = 32'hB212EA93;
		rd_key = seed[7:0];
		lsb = 1'h0;
		srst = 1'h1;
		repeat (6) @(posedge sys_clk);
		srst <= 1'h0;
		repeat (3) @(posedge sys_clk);
		chk_b(idx2, tcsp_pkg::INDEX_2_RST);
		chk_b({7'h0, lsb_first}, 8'h0);
		frame(1'h1, 2'h0, tcsp_pkg::ADDR_PORT_CONFIG, 1, 32'h18000000, 0, 0);
		// every length code, both directions, random stalls
		for (int k = 0; k < 8; k++) begin
			seed = xs(seed);
			a = {2'h1, seed[10:0]};
			d = {rdv(a), rdv(a - 13'h1), rdv(a - 13'h2), rdv(a - 13'h3)};
			if (k < 4) d = xs(seed);
			frame(k[2], k[1:0], a, (k[1:0] == 2'h3) ? 4 : k[1:0] + 1, d,
				(k[1:0] != 2'h3) && seed[0], 0);
			drain();
		end
		// abort four bits into a data byte
		tcsp_host_i.sel(1'h0);
		tcsp_host_i.shift(16'h0A00, 16, 1'h0, r);
		tcsp_host_i.shift(16'h000F, 4, 1'h0, r);
		tcsp_host_i.sel(1'h1);
		frame(1'h0, 2'h0, 13'h0A01, 1, 32'hC3000000, 0, 0);
		drain();
		// index writes held until the transfer bit
		frame(1'h0, 2'h1, tcsp_pkg::ADDR_INDEX_1, 2, 32'h2A150000, 1, 0);
		drain();
		chk_b(idx1, 8'h0F);
		frame(1'h1, 2'h1, tcsp_pkg::ADDR_INDEX_1, 2, 32'h2A150000, 0, 0);
		frame(1'h0, 2'h0, tcsp_pkg::ADDR_UPDATE, 1, 32'h01000000, 0, 0);
		drain();
		chk_b(idx1, 8'h2A);
		chk_b(idx2, 8'h15);
		// mirrored order bits switch to lsb first and back
		frame(1'h0, 2'h0, tcsp_pkg::ADDR_PORT_CONFIG, 1, 32'h42000000, 0, 0);
		drain();
		chk_b({7'h0, lsb_first}, 8'h1);
		lsb = 1'h1;
		frame(1'h0, 2'h2, 13'h0A10, 3, xs(seed), 1, 0);
		frame(1'h1, 2'h0, tcsp_pkg::ADDR_PORT_CONFIG, 1, 32'h5A000000, 0, 0);
		frame(1'h0, 2'h0, tcsp_pkg::ADDR_PORT_CONFIG, 1, 32'h00000000, 0, 0);
		drain();
		lsb = 1'h0;
		chk_b({7'h0, lsb_first}, 8'h0);
		// select held low across frames
		frame(1'h0, 2'h0, 13'h0B00, 1, 32'h96000000, 0, 1);
		frame(1'h0, 2'h1, 13'h0B20, 2, 32'h3CA50000, 0, 1);
		frame(1'h1, 2'h0, 13'h0B40, 1, {rdv(13'h0B40), 24'h0}, 0, 0);
		drain();
		// two-wire streaming: sixteen more bits are data, not a new instruction
		frame(1'h0, 2'h3, 13'h0C00, 4, xs(seed), 0, 1);
		tcsp_host_i.shift(16'h0000, 16, 1'h0, r);
		eq.push_back({13'h0BFC, 8'h00});
		eq.push_back({13'h0BFB, 8'h00});
		drain();
		chk_b({7'h0, streaming}, 8'h1);
		// mid-run reset is the only way out; state and outputs start over
		seed = xs(seed);
		rd_key = seed[7:0];
		@(posedge sys_clk);
		srst <= 1'h1;
		repeat (6) @(posedge sys_clk);
		chk_b({7'h0, streaming}, 8'h0);
		chk_b(idx1, tcsp_pkg::INDEX_1_RST);
		srst <= 1'h0;
		repeat (3) @(posedge sys_clk);
		frame(1'h1, 2'h1, tcsp_pkg::ADDR_INDEX_1, 2, 32'h0F0F0000, 0, 0);
		frame(1'h1, 2'h0, 13'h0B41, 1, {rdv(13'h0B41), 24'h0}, 0, 0);
		drain();
		wrap_up();
	end
endmodule // tcsp_port_bench
